//--- design/usmc_pkg.sv
// constants for the uart status and modem control block
package usmc_pkg;
   // ==========================================
   // register byte addresses
   localparam logic [4:0] ADDR_LINE_STATUS = 5'h00;
   localparam logic [4:0] ADDR_MODEM_CTRL = 5'h04;
   localparam logic [4:0] ADDR_MODEM_STATUS = 5'h08;
   localparam logic [4:0] ADDR_INT_ENABLE = 5'h0C;
   localparam logic [4:0] ADDR_ENH_FEATURE = 5'h10;
   localparam logic [4:0] ADDR_HOLDING = 5'h14;
   // ==========================================
   // reset values
   localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
   localparam logic [7:0] INT_ENABLE_RST = 8'h00;
   localparam logic [7:0] ENH_FEATURE_RST = 8'h00;
   // ==========================================
   // line status fields
   localparam int LS_DATA_READY = 0;
   localparam int LS_OVERRUN = 1;
   localparam int LS_HEAD_LO = 2;
   localparam int LS_HEAD_HI = 4;
   localparam int LS_THR_EMPTY = 5;
   localparam int LS_TX_IDLE = 6;
   localparam int LS_FIFO_ERR = 7;
   // ==========================================
   // modem control fields
   localparam int MC_DTR = 0;
   localparam int MC_RTS = 1;
   localparam int MC_FIFO_RDY = 2;
   localparam int MC_INT_DRIVE = 3;
   localparam int MC_LOOPBACK = 4;
   localparam int MC_XON_ANY = 5;
   localparam int MC_CTL_ACCESS = 6;
   localparam int MC_PRESCALE = 7;
   localparam int ENH_LO = 5;
   // ==========================================
   // interrupt enable fields
   localparam int IE_RX = 0;
   localparam int IE_THR = 1;
   localparam int IE_LINE = 2;
   localparam int IE_MODEM = 3;
   localparam int IE_SLEEP = 4;
   localparam int IE_XOFF = 5;
   localparam int IE_RTS = 6;
   localparam int IE_CTS = 7;
   localparam int IE_ENH_LO = 4;
   // ==========================================
   // enhanced feature fields
   localparam int EF_ENABLE = 4;
   localparam int EF_AUTO_RTS = 6;
   // ==========================================
   // modem status fields
   localparam int MS_RI_DELTA = 2;
   localparam int MS_LINE_LO = 4;
   // ==========================================
   // prescaler
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
endpackage

//--- design/usmc_top.sv
// status, modem control and interrupt enable logic of the uart
// Contract
// - data ready reads 1 while the receive fifo holds a character
// - overrun bit sets when an incoming character could not be stored
// - bits 4:2 show break, framing, parity of the next character
// - framing and break flags of received characters reported as given
// - bit 5 shows transmit holding register empty
// - bit 6 shows holding and shift registers both empty
// - bit 7 set while any erroneous character remains in receive fifo
// - line status read keeps fifo pointer; holding read advances it
// - control bits 0 and 1 drive terminal ready and request to send low; loopback holds both high
// - auto request to send makes that output follow flow control
// - control bit 2 enables the fifo ready status register outside loopback
// - control bit 3 lets the interrupt output be driven, else floats
// - control bit 4 loops transmit to receive and control to status
// - loopback status 7:4 equal control 3,2,0,1; deltas track them
// - control bit 5 enables resume on any character
// - control bit 6 opens transmission control and trigger registers while enhanced enable is set
// - control bit 7 selects divide by four of the input clock
// - control 7:5 and enable 7:4 writable only with enhanced enable
// - deltas latch line changes, ring only falling (rising in loopback); cleared on read
// - outside loopback status 7:4 are inverted modem inputs
// - enable bits gate rx, thr, line, modem, xoff, rts, cts sources
// - enable bit 4 sleeps; re-setting bit 1 below threshold raises a thr interrupt
// - enhanced enable bit blocks or permits enhanced field writes
`timescale 1ns/1ps
`default_nettype none
module usmc_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic rx_nonempty,
   input wire logic [2:0] rx_head_flags,
   input wire logic [7:0] rx_head_data,
   input wire logic rx_any_error,
   input wire logic rx_overrun_evt,
   input wire logic rx_trigger,
   output logic rx_pop,
   output logic [7:0] tx_data,
   output logic tx_push,
   input wire logic thr_empty,
   input wire logic tsr_empty,
   input wire logic tx_below_thresh,
   input wire logic tx_serial,
   output logic tx_pin,
   input wire logic rx_pin,
   output logic rx_serial,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic cd_n,
   output logic dtr_n,
   output logic rts_n,
   input wire logic auto_rts_n,
   input wire logic xoff_evt,
   input wire logic rts_evt,
   input wire logic cts_evt,
   output logic int_out,
   output logic int_oe,
   output logic fifo_ready_en,
   output logic ctl_access_en,
   output logic xon_any_en,
   output logic sleep_en,
   output logic auto_rts_en,
   output logic clk_tick
);
   // ==========================================
   // state
   typedef struct packed {
      logic [7:0] modem_control;
      logic [7:0] interrupt_enable;
      logic [7:0] enhanced_feature;
      logic ovr;
      logic [3:0] delta;
      logic [3:0] prev;
      logic thr_pend;
      logic below_prev;
      logic ack;
      logic [7:0] rdata;
      logic [7:0] txd;
      logic [1:0] pre;
      logic irq;
   } usmc_state_s;

   usmc_state_s st_ff;
   usmc_state_s nxt_st;

   logic loop;
   logic [3:0] line_now;
   logic [3:0] chg;
   logic ri_edge;
   logic [7:0] ls_val;
   logic [7:0] ms_val;
   logic [6:0] pend;
   logic done;
   logic wr_ok;
   logic ms_rd;
   logic ls_rd;

   localparam int MS_RI = usmc_pkg::MS_RI_DELTA;

   // ==========================================
   // combinational views
   always_comb begin
      loop = st_ff.modem_control[usmc_pkg::MC_LOOPBACK];
      // status bit order 7:4 is cd, ri, dsr, cts
      if (loop) begin
         line_now = {st_ff.modem_control[usmc_pkg::MC_INT_DRIVE],
                     st_ff.modem_control[usmc_pkg::MC_FIFO_RDY],
                     st_ff.modem_control[usmc_pkg::MC_DTR],
                     st_ff.modem_control[usmc_pkg::MC_RTS]};
      end else begin
         line_now = ~{cd_n, ri_n, dsr_n, cts_n};
      end
      chg = line_now ^ st_ff.prev;
      if (loop) begin
         ri_edge = line_now[2] & ~st_ff.prev[2];
      end else begin
         ri_edge = st_ff.prev[2] & ~line_now[2];
      end
      ls_val = 8'h00;
      ls_val[usmc_pkg::LS_DATA_READY] = rx_nonempty;
      ls_val[usmc_pkg::LS_OVERRUN] = st_ff.ovr;
      ls_val[usmc_pkg::LS_HEAD_HI:usmc_pkg::LS_HEAD_LO] = rx_head_flags;
      ls_val[usmc_pkg::LS_THR_EMPTY] = thr_empty;
      ls_val[usmc_pkg::LS_TX_IDLE] = thr_empty & tsr_empty;
      ls_val[usmc_pkg::LS_FIFO_ERR] = rx_any_error;
      ms_val = {line_now, st_ff.delta};
      pend[0] = st_ff.interrupt_enable[usmc_pkg::IE_RX] & rx_trigger;
      pend[1] = st_ff.interrupt_enable[usmc_pkg::IE_THR] & st_ff.thr_pend;
      pend[2] = st_ff.interrupt_enable[usmc_pkg::IE_LINE] & (st_ff.ovr | rx_any_error);
      pend[3] = st_ff.interrupt_enable[usmc_pkg::IE_MODEM] & (|st_ff.delta);
      pend[4] = st_ff.interrupt_enable[usmc_pkg::IE_XOFF] & xoff_evt;
      pend[5] = st_ff.interrupt_enable[usmc_pkg::IE_RTS] & rts_evt;
      pend[6] = st_ff.interrupt_enable[usmc_pkg::IE_CTS] & cts_evt;
      done = st_ff.ack & (read | write);
      wr_ok = done & write & byteenable[0];
      ms_rd = done & read & (address == usmc_pkg::ADDR_MODEM_STATUS);
      ls_rd = done & read & (address == usmc_pkg::ADDR_LINE_STATUS);
   end

   // ==========================================
   // next state
   always_comb begin
      nxt_st = st_ff;
      // bus: first cycle captures read data, second completes
      nxt_st.ack = (read | write) & ~st_ff.ack;
      if ((read | write) & ~st_ff.ack) begin
         unique case (address)
            usmc_pkg::ADDR_LINE_STATUS: nxt_st.rdata = ls_val;
            usmc_pkg::ADDR_MODEM_CTRL: nxt_st.rdata = st_ff.modem_control;
            usmc_pkg::ADDR_MODEM_STATUS: nxt_st.rdata = ms_val;
            usmc_pkg::ADDR_INT_ENABLE: nxt_st.rdata = st_ff.interrupt_enable;
            usmc_pkg::ADDR_ENH_FEATURE: nxt_st.rdata = st_ff.enhanced_feature;
            usmc_pkg::ADDR_HOLDING: nxt_st.rdata = rx_head_data;
            default: nxt_st.rdata = 8'h00;
         endcase
         if (write & byteenable[0]) begin
            nxt_st.txd = writedata[7:0];
         end
      end
      // register writes
      if (wr_ok) begin
         unique case (address)
            usmc_pkg::ADDR_MODEM_CTRL: begin
               nxt_st.modem_control[usmc_pkg::ENH_LO-1:0] = writedata[usmc_pkg::ENH_LO-1:0];
               if (st_ff.enhanced_feature[usmc_pkg::EF_ENABLE]) begin
                  nxt_st.modem_control[7:usmc_pkg::ENH_LO] = writedata[7:usmc_pkg::ENH_LO];
               end
            end
            usmc_pkg::ADDR_INT_ENABLE: begin
               nxt_st.interrupt_enable[usmc_pkg::IE_ENH_LO-1:0] = writedata[usmc_pkg::IE_ENH_LO-1:0];
               if (st_ff.enhanced_feature[usmc_pkg::EF_ENABLE]) begin
                  nxt_st.interrupt_enable[7:usmc_pkg::IE_ENH_LO] = writedata[7:usmc_pkg::IE_ENH_LO];
               end
            end
            usmc_pkg::ADDR_ENH_FEATURE: nxt_st.enhanced_feature = writedata[7:0];
            default: begin
            end
         endcase
      end
      // fresh thr interrupt on threshold crossing or re-enable
      nxt_st.below_prev = tx_below_thresh;
      if (~tx_below_thresh | (done & write & (address == usmc_pkg::ADDR_HOLDING))) begin
         nxt_st.thr_pend = 1'b0;
      end
      if (tx_below_thresh & ~st_ff.below_prev) begin
         nxt_st.thr_pend = 1'b1;
      end
      if (tx_below_thresh & ~st_ff.interrupt_enable[usmc_pkg::IE_THR] &
          nxt_st.interrupt_enable[usmc_pkg::IE_THR]) begin
         nxt_st.thr_pend = 1'b1;
      end
      // overrun: clears only what the read returned, set wins
      nxt_st.ovr = (st_ff.ovr & ~(ls_rd & st_ff.rdata[usmc_pkg::LS_OVERRUN]))
                   | rx_overrun_evt;
      // modem deltas
      nxt_st.prev = line_now;
      nxt_st.delta = st_ff.delta & ~(ms_rd ? st_ff.rdata[3:0] : 4'h0);
      nxt_st.delta[0] = nxt_st.delta[0] | chg[0];
      nxt_st.delta[1] = nxt_st.delta[1] | chg[1];
      nxt_st.delta[MS_RI] = nxt_st.delta[MS_RI] | ri_edge;
      nxt_st.delta[3] = nxt_st.delta[3] | chg[3];
      // clock prescaler
      if (st_ff.pre == usmc_pkg::PRESCALE_LAST) begin
         nxt_st.pre = 2'h0;
      end else begin
         nxt_st.pre = st_ff.pre + 2'h1;
      end
      nxt_st.irq = |pend;
   end

   // ==========================================
   // registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff <= '0;
         st_ff.modem_control <= usmc_pkg::MODEM_CTRL_RST;
         st_ff.interrupt_enable <= usmc_pkg::INT_ENABLE_RST;
         st_ff.enhanced_feature <= usmc_pkg::ENH_FEATURE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================
   // outputs
   always_comb begin
      waitrequest = (read | write) & ~st_ff.ack;
      readdata = {24'h000000, st_ff.rdata};
      rx_pop = done & read & (address == usmc_pkg::ADDR_HOLDING);
      tx_push = done & write & byteenable[0] & (address == usmc_pkg::ADDR_HOLDING);
      tx_data = st_ff.txd;
      tx_pin = loop ? 1'b1 : tx_serial;
      rx_serial = loop ? tx_serial : rx_pin;
      dtr_n = loop | ~st_ff.modem_control[usmc_pkg::MC_DTR];
      if (st_ff.enhanced_feature[usmc_pkg::EF_AUTO_RTS]) begin
         rts_n = loop | auto_rts_n;
      end else begin
         rts_n = loop | ~st_ff.modem_control[usmc_pkg::MC_RTS];
      end
      int_out = st_ff.irq;
      int_oe = st_ff.modem_control[usmc_pkg::MC_INT_DRIVE];
      fifo_ready_en = st_ff.modem_control[usmc_pkg::MC_FIFO_RDY] & ~loop;
      ctl_access_en = st_ff.enhanced_feature[usmc_pkg::EF_ENABLE] &
                      st_ff.modem_control[usmc_pkg::MC_CTL_ACCESS];
      xon_any_en = st_ff.modem_control[usmc_pkg::MC_XON_ANY];
      sleep_en = st_ff.interrupt_enable[usmc_pkg::IE_SLEEP];
      auto_rts_en = st_ff.enhanced_feature[usmc_pkg::EF_AUTO_RTS];
      if (st_ff.modem_control[usmc_pkg::MC_PRESCALE]) begin
         clk_tick = (st_ff.pre == usmc_pkg::PRESCALE_LAST);
      end else begin
         clk_tick = 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- testbench/usmc_asserts.sv
// port assertions for the uart status and modem control block
`timescale 1ns/1ps
`default_nettype none
module usmc_asserts (
   input wire logic clk,
   input wire logic reset,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic waitrequest,
   input wire logic [31:0] readdata,
   input wire logic rx_nonempty,
   input wire logic [2:0] rx_head_flags,
   input wire logic rx_any_error,
   input wire logic rx_overrun_evt,
   input wire logic rx_pop,
   input wire logic thr_empty,
   input wire logic tsr_empty,
   input wire logic tx_serial,
   input wire logic tx_pin,
   input wire logic rx_pin,
   input wire logic rx_serial,
   input wire logic dtr_n,
   input wire logic rts_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ==========================================
   // line status reads, fifo pop and loopback
   sequence s_ls;
      read && !waitrequest && address == usmc_pkg::ADDR_LINE_STATUS;
   endsequence
   sequence s_ovf;
      rx_overrun_evt ##3 s_ls;
   endsequence
   property p_ready; s_ls |-> readdata[0] == $past(rx_nonempty); endproperty
   a_ready: assert property (p_ready) else $error("data ready bit wrong");
   property p_ovf; s_ovf |-> readdata[1]; endproperty
   a_ovf: assert property (p_ovf) else $error("overrun bit lost");
   property p_head; s_ls |-> readdata[4:2] == $past(rx_head_flags); endproperty
   a_head: assert property (p_head) else $error("head flags wrong");
   property p_tx; s_ls |-> readdata[6] == ($past(thr_empty) && $past(tsr_empty)); endproperty
   a_tx: assert property (p_tx) else $error("transmitter idle bit wrong");
   property p_thr; s_ls |-> readdata[5] == $past(thr_empty); endproperty
   a_thr: assert property (p_thr) else $error("holding empty bit wrong");
   property p_err; s_ls |-> readdata[7] == $past(rx_any_error); endproperty
   a_err: assert property (p_err) else $error("fifo error bit wrong");
   property p_pop; rx_pop == (read && !waitrequest && address == usmc_pkg::ADDR_HOLDING); endproperty
   a_pop: assert property (p_pop) else $error("fifo pop wrong");
   property p_loop; tx_pin != tx_serial |-> rx_serial == tx_serial && dtr_n && rts_n; endproperty
   a_loop: assert property (p_loop) else $error("loopback path wrong");
   property p_pins; rx_serial != rx_pin |-> tx_pin; endproperty
   a_pins: assert property (p_pins) else $error("loopback pin not idle");
endmodule
bind usmc_top usmc_asserts u_asserts (.*);
`default_nettype wire

//--- testbench/usmc_modem.sv
// modem model driving the active low status lines
`timescale 1ns/1ps
`default_nettype none
module usmc_modem (
   input wire logic clk,
   input wire logic [3:0] lines,
   output logic cts_n,
   output logic dsr_n,
   output logic ri_n,
   output logic cd_n
);
   // ==========================================
   // lines come active high as {cd, ri, dsr, cts}
   initial {cd_n, ri_n, dsr_n, cts_n} = 4'hF;
   always @(posedge clk) begin
      {cd_n, ri_n, dsr_n, cts_n} <= ~lines;
   end
endmodule
`default_nettype wire

//--- testbench/test_uart_status_modem_ctrl.sv
// self-checking bench for the uart status and modem control block
`timescale 1ns/1ps
`default_nettype none
module test_uart_status_modem_ctrl;
   localparam logic [4:0] LS = usmc_pkg::ADDR_LINE_STATUS, MC = usmc_pkg::ADDR_MODEM_CTRL;
   localparam logic [4:0] MS = usmc_pkg::ADDR_MODEM_STATUS, IE = usmc_pkg::ADDR_INT_ENABLE;
   localparam logic [4:0] EF = usmc_pkg::ADDR_ENH_FEATURE, HD = usmc_pkg::ADDR_HOLDING;
   logic clk = 1'h0, reset = 1'h1, read = 1'h0, write = 1'h0, tx_below_thresh = 1'h0;
   logic rx_overrun_evt = 1'h0, auto_rts_n = 1'h0;
   logic [4:0] address = 5'h00;
   logic [3:0] byteenable = 4'hF, lines = 4'h0, src = 4'h0, p;
   logic [31:0] writedata = 32'h0, readdata;
   logic [8:0] r = 9'h000;
   logic [7:0] rx_head_data = 8'h00, tx_data, q, v, t;
   logic waitrequest, rx_pop, tx_push, tx_pin, rx_serial, cts_n, dsr_n, ri_n, cd_n;
   logic dtr_n, rts_n, int_out, int_oe, fifo_ready_en, ctl_access_en, xon_any_en;
   logic sleep_en, auto_rts_en, clk_tick, pushed;
   int errors = 0, n_compared = 0, i, b;
   usmc_top u_dut (.*, .rx_nonempty(r[0]), .rx_head_flags(r[3:1]), .rx_any_error(r[4]),
      .thr_empty(r[5]), .tsr_empty(r[6]), .tx_serial(r[7]), .rx_pin(r[8]),
      .rx_trigger(src[0]), .xoff_evt(src[1]), .rts_evt(src[2]), .cts_evt(src[3]));
   usmc_modem u_modem (.*);
   // ==========================================
   // bus cycles, compare and closing
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("mismatch %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      read <= !w;
      write <= w;
      writedata <= {24'h0, d};
      @(posedge clk);
      while (waitrequest !== 1'h0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk({7'h00, waitrequest}, 8'h00);
      q = readdata[7:0];
      pushed = tx_push;
      read <= 1'h0;
      write <= 1'h0;
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always #50 clk = ~clk;
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      finish_test;
   end
   initial begin
      void'($urandom(72921));
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      bus(MC, 1'h0, 8'h00);
      chk(q, usmc_pkg::MODEM_CTRL_RST);
      bus(MC, 1'h1, 8'hFF);
      bus(MC, 1'h0, 8'h00);
      chk(q, 8'h1F);
      bus(EF, 1'h1, 8'h10);
      repeat (16) begin
         @(posedge clk);
         r <= 9'($urandom);
         v = 8'($urandom);
         bus(MC, 1'h1, v);
         bus(MC, 1'h0, 8'h00);
         chk(q, v);
         t = {v[2] & ~v[4], v[6], v[5], v[3], ~v[0] | v[4], ~v[1] | v[4], 2'h0};
         chk({fifo_ready_en, ctl_access_en, xon_any_en, int_oe, dtr_n, rts_n, 2'h0}, t);
         bus(MS, 1'h0, 8'h00);
         chk(q & 8'hF0, v[4] ? {v[3], v[2], v[0], v[1], 4'h0} : {lines, 4'h0});
         t = 8'h00;
         repeat (8) begin
            @(negedge clk);
            t += 8'(clk_tick);
         end
         chk(t, v[7] ? 8'h02 : 8'h08);
      end
      bus(EF, 1'h1, 8'h50);
      bus(MC, 1'h1, 8'h00);
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         auto_rts_n <= i[0];
         @(negedge clk);
         chk({auto_rts_en, rts_n, 6'h00}, {1'h1, i[0], 6'h00});
      end
      bus(EF, 1'h1, 8'h10);
      bus(MS, 1'h0, 8'h00);
      repeat (8) begin
         p = lines;
         @(posedge clk);
         lines <= 4'($urandom);
         repeat (3) @(posedge clk);
         bus(MS, 1'h0, 8'h00);
         chk(q, {lines, lines[3] ^ p[3], p[2] & ~lines[2], lines[1:0] ^ p[1:0]});
         bus(MS, 1'h0, 8'h00);
         chk(q, {lines, 4'h0});
      end
      repeat (8) begin
         @(posedge clk);
         r <= 9'($urandom);
         rx_head_data <= 8'($urandom);
         rx_overrun_evt <= 1'h1;
         @(posedge clk);
         rx_overrun_evt <= 1'h0;
         bus(LS, 1'h0, 8'h00);
         chk(q, {r[4], r[5] & r[6], r[5], r[3:1], 1'h1, r[0]});
         bus(LS, 1'h0, 8'h00);
         chk(q & 8'h02, 8'h00);
         bus(HD, 1'h0, 8'h00);
         chk(q, rx_head_data);
      end
      for (i = 0; i < 4; i++) begin
         b = (i == 0) ? 0 : i + 4;
         @(posedge clk);
         src <= 4'(1 << i);
         bus(IE, 1'h1, 8'hE1 & ~8'(1 << b));
         repeat (2) @(negedge clk);
         chk({7'h00, int_out}, 8'h00);
         bus(IE, 1'h1, 8'(1 << b));
         repeat (2) @(negedge clk);
         chk({7'h00, int_out}, 8'h01);
      end
      @(posedge clk);
      src <= 4'h0;
      tx_below_thresh <= 1'h1;
      bus(IE, 1'h1, 8'h02);
      repeat (2) @(negedge clk);
      chk({7'h00, int_out}, 8'h01);
      bus(HD, 1'h1, 8'hA5);
      chk({7'h00, pushed}, 8'h01);
      repeat (2) @(negedge clk);
      chk(tx_data, 8'hA5);
      chk({7'h00, int_out}, 8'h00);
      bus(IE, 1'h1, 8'h00);
      bus(IE, 1'h1, 8'h02);
      repeat (2) @(negedge clk);
      chk({7'h00, int_out}, 8'h01);
      byteenable <= 4'h0;
      bus(IE, 1'h1, 8'h10);
      byteenable <= 4'hF;
      bus(IE, 1'h0, 8'h00);
      chk(q, 8'h02);
      bus(5'h1C, 1'h0, 8'h00);
      chk(q, 8'h00);
      bus(IE, 1'h1, 8'h10);
      @(negedge clk);
      chk({7'h00, sleep_en}, 8'h01);
      finish_test;
   end
endmodule
`default_nettype wire
